// >>> rtl/cwr_top.sv
// Configuration word store, decode and start-up reset sequencing.
// Functional notes
// - Data array stays accessible under code protection.
// - Power-up delay holds reset 72 ms.
// - Start-up timer waits for stable crystal.
// - Watchdog runs from own RC oscillator.
// - Brown-out condition forces device reset.
// - Sleep ends on external reset, watchdog, interrupt.
// - Programmed bit reads zero, unprogrammed one.
// - Configuration word lives at 2007h.
// - Config space reachable only in programming.
// - Fourteen-bit word, protect bit 13.
// - Protect bit zero guards variant range.
// - Brown-out enable bit one enables it.
// - Three-bit field selects clock source.
`timescale 1ns/100ps
`default_nettype none
module cwr_top
  import cwr_pkg::*;
#(
  parameter int POWERUP_DELAY_TIMER_CYC = cwr_pkg::CWR_POWERUP_DELAY_TIMER_CYC,
  parameter int OST_CYC = cwr_pkg::CWR_OST_CYC,
  parameter int WDT_CYC = cwr_pkg::CWR_WDT_CYC,
  parameter logic [1:0] VARIANT = 2'h2
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic power_on_i,
  input wire logic ext_reset_n_i,
  input wire logic brownout_i,
  input wire logic wdt_rc_i,
  input wire logic osc_stable_i,
  input wire logic prog_mode_i,
  input wire cwr_pkg::cwr_prog_req_t prog_i,
  input wire logic [13:0] cpu_fetch_addr_i,
  input wire logic cpu_sleep_i,
  input wire logic cpu_wdt_clear_i,
  input wire logic irq_pending_i,
  input wire logic cpu_data_rd_i,
  input wire logic cpu_data_wr_i,
  output logic [13:0] prog_rdata_o,
  output logic device_reset_o,
  output logic asleep_o,
  output logic wake_o,
  output logic fetch_blocked_o,
  output logic data_rd_grant_o,
  output logic data_wr_grant_o,
  output logic wdt_timeout_o,
  output cwr_pkg::cwr_cfg_t cfg_o
);
  import cwr_pkg::*;

  typedef enum logic [3:0] {
    CWR_ST_RESET = 4'h1,
    CWR_ST_POWERUP_DELAY_TIMER = 4'h2,
    CWR_ST_OST = 4'h4,
    CWR_ST_RUN = 4'h8
  } cwr_state_t;

  // Decode a raw word into settings.
  function automatic cwr_cfg_t cwr_decode(input logic [13:0] w);
    cwr_cfg_t c;
    logic [2:0] f;
    f = {w[CWR_B_FOSC2], w[CWR_B_FOSC1], w[CWR_B_FOSC0]};
    c.program_protect_bit = w[CWR_B_PROTECT];
    c.data_array_protect_bit = w[CWR_B_DATA_PROT];
    c.low_voltage_programming_en = w[CWR_B_LVP];
    c.brownout_reset_en = w[CWR_B_BOR_EN];
    c.external_reset_pin_en = w[CWR_B_EXT_RST];
    c.powerup_delay_en = ~w[CWR_B_POWERUP_DELAY_TIMER_EN];
    c.watchdog_en = w[CWR_B_WDT_EN];
    c.osc_source_select = f;
    c.clkout_en = (f == CWR_OSC_RC_CLK) || (f == CWR_OSC_INT_CLK);
    c.crystal = (f == CWR_OSC_HS) || (f == CWR_OSC_XT) || (f == CWR_OSC_LP);
    unique case (f)
      CWR_OSC_RC_CLK, CWR_OSC_RC_IO: c.source = CWR_SRC_RC;
      CWR_OSC_INT_CLK, CWR_OSC_INT_IO: c.source = CWR_SRC_INT;
      CWR_OSC_EXT: c.source = CWR_SRC_EXT;
      CWR_OSC_HS: c.source = CWR_SRC_HS;
      CWR_OSC_XT: c.source = CWR_SRC_XT;
      CWR_OSC_LP: c.source = CWR_SRC_LP;
    endcase
    return c;
  endfunction : cwr_decode

  // Top of the protected program range for the selected variant.
  function automatic logic [13:0] cwr_prot_top(input logic [1:0] v);
    unique case (v)
      2'h2: return CWR_PROT_TOP_L;
      2'h1: return CWR_PROT_TOP_M;
      default: return CWR_PROT_TOP_S;
    endcase
  endfunction : cwr_prot_top

  // Pins from outside the clock domain.
  // The reset pin is inverted before the flops, so their cleared state means idle.
  logic por_s, ext_s, bor_s, rc_s, oscok_s, pgm_s;
  cwr_sync #(.W(6)) u_sync (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .d_i({power_on_i, ~ext_reset_n_i, brownout_i, wdt_rc_i, osc_stable_i, prog_mode_i}),
    .q_o({por_s, ext_s, bor_s, rc_s, oscok_s, pgm_s})
  );

  logic [13:0] cfg_word_r;
  cwr_cfg_t cfg_r;
  cwr_state_t state_r;
  logic [31:0] cnt_r;
  logic rc_prev_r, por_prev_r, por_seen_r, sleep_r, wdt_to;
  logic ext_rst, bor_rst, cfg_hit, por_edge, rc_tick, hold_rst;

  assign cfg_hit = pgm_s && (prog_i.addr == CWR_CFG_ADDR);
  assign ext_rst = cfg_r.external_reset_pin_en && ext_s;
  assign bor_rst = cfg_r.brownout_reset_en && bor_s;
  assign por_edge = por_s && !por_prev_r;
  assign rc_tick = rc_s && !rc_prev_r;
  assign hold_rst = ext_rst || bor_rst || (wdt_to && !sleep_r) || por_edge;

  // Nonvolatile word: written only by the programmer inside the config space.
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cfg_word_r <= CWR_CFG_ERASED;
    end else if (ce_i && cfg_hit && prog_i.wr) begin
      cfg_word_r <= prog_i.wdata & CWR_CFG_IMPL_MASK;
    end
  end

  // Programmer read port; zero outside programming mode or the word address.
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      prog_rdata_o <= 14'h0;
    end else if (ce_i) begin
      prog_rdata_o <= (cfg_hit && prog_i.rd) ? cfg_word_r : 14'h0;
    end
  end

  // Settings latched while reset is held, frozen in run.
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cfg_r <= cwr_decode(CWR_CFG_ERASED);
    end else if (ce_i && state_r != CWR_ST_RUN) begin
      cfg_r <= cwr_decode(cfg_word_r);
    end
  end

  // Edge history of the power and RC tick inputs.
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rc_prev_r <= 1'b0;
      por_prev_r <= 1'b0;
    end else if (ce_i) begin
      rc_prev_r <= rc_s;
      por_prev_r <= por_s;
    end
  end

  // Power-on marker: the supply level alone cannot tell a power-up from a later reset.
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      por_seen_r <= 1'b0;
    end else if (ce_i) begin
      if (por_edge) begin
        por_seen_r <= 1'b1;
      end else if (state_r != CWR_ST_RESET) begin
        por_seen_r <= 1'b0;
      end
    end
  end

  // Reset sequencer: delay timer only after power-up, then crystal wait.
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_r <= CWR_ST_RESET;
      cnt_r <= 32'h0;
    end else if (ce_i) begin
      if (hold_rst) begin
        state_r <= CWR_ST_RESET;
        cnt_r <= 32'h0;
      end else begin
        unique case (state_r)
          CWR_ST_RESET: begin
            cnt_r <= 32'h0;
            if (por_seen_r && cfg_r.powerup_delay_en) begin
              state_r <= CWR_ST_POWERUP_DELAY_TIMER;
            end else begin
              state_r <= CWR_ST_OST;
            end
          end
          CWR_ST_POWERUP_DELAY_TIMER: begin
            if (cnt_r == 32'(POWERUP_DELAY_TIMER_CYC - 1)) begin
              cnt_r <= 32'h0;
              state_r <= CWR_ST_OST;
            end else begin
              cnt_r <= cnt_r + 32'h1;
            end
          end
          CWR_ST_OST: begin
            if (!cfg_r.crystal) begin
              state_r <= CWR_ST_RUN;
            end else if (oscok_s && cnt_r >= 32'(OST_CYC - 1)) begin
              state_r <= CWR_ST_RUN;
            end else if (oscok_s) begin
              cnt_r <= cnt_r + 32'h1;
            end else begin
              cnt_r <= 32'h0;
            end
          end
          CWR_ST_RUN: state_r <= CWR_ST_RUN;
        endcase
      end
    end
  end

  cwr_watchdog #(.LIMIT(WDT_CYC)) u_wdt (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .enable_i(cfg_r.watchdog_en && state_r == CWR_ST_RUN),
    .rc_tick_i(rc_tick),
    .clear_i(cpu_wdt_clear_i),
    .timeout_o(wdt_to)
  );

  // Sleep state and wake sources.
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sleep_r <= 1'b0;
      wake_o <= 1'b0;
    end else if (ce_i) begin
      wake_o <= 1'b0;
      if (ext_rst || (sleep_r && (wdt_to || irq_pending_i))) begin
        sleep_r <= 1'b0;
        wake_o <= sleep_r;
      end else if (cpu_sleep_i && state_r == CWR_ST_RUN) begin
        sleep_r <= 1'b1;
      end
    end
  end

  // Registered outputs.
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      device_reset_o <= 1'b1;
      asleep_o <= 1'b0;
      fetch_blocked_o <= 1'b0;
      data_rd_grant_o <= 1'b0;
      data_wr_grant_o <= 1'b0;
      wdt_timeout_o <= 1'b0;
      cfg_o <= cwr_decode(CWR_CFG_ERASED);
    end else if (ce_i) begin
      device_reset_o <= hold_rst || state_r != CWR_ST_RUN;
      asleep_o <= sleep_r;
      fetch_blocked_o <= pgm_s && !cfg_r.program_protect_bit
                         && cpu_fetch_addr_i <= cwr_prot_top(VARIANT);
      data_rd_grant_o <= cpu_data_rd_i && state_r == CWR_ST_RUN;
      data_wr_grant_o <= cpu_data_wr_i && state_r == CWR_ST_RUN;
      wdt_timeout_o <= wdt_to;
      cfg_o <= cfg_r;
    end
  end

  a_cfg_frozen_run: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (ce_i && $past(ce_i) && state_r == CWR_ST_RUN && $past(state_r) == CWR_ST_RUN)
    |-> $stable(cfg_r))
    else $error("settings changed while running");
  a_bor_forces_reset: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (ce_i && bor_rst) |=> device_reset_o)
    else $error("brown-out did not reset the device");
  a_prot_bit_pos: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (ce_i && state_r != CWR_ST_RUN)
    |=> cfg_r.program_protect_bit == $past(cfg_word_r[CWR_B_PROTECT]))
    else $error("protect bit decode broken");
  a_no_cfg_outside: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (ce_i && !pgm_s && prog_i.rd) |=> prog_rdata_o == 14'h0)
    else $error("config word readable outside programming mode");
  a_reserved_zero: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    cfg_word_r[12:9] == 4'h0)
    else $error("unimplemented config bits not zero");
  a_ost_waits_osc: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (state_r == CWR_ST_OST && cfg_r.crystal && !oscok_s) |=> state_r != CWR_ST_RUN)
    else $error("left start-up wait without stable oscillator");
  a_wake_on_irq: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (ce_i && sleep_r && irq_pending_i) |=> !sleep_r)
    else $error("interrupt did not end sleep");
  a_data_open: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (ce_i && cpu_data_rd_i && state_r == CWR_ST_RUN) |=> data_rd_grant_o)
    else $error("data read refused");
  // Later resets must skip the power-up delay.
  a_powerup_delay_timer_only_por: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (ce_i && !hold_rst && state_r == CWR_ST_RESET && !por_seen_r) |=> state_r != CWR_ST_POWERUP_DELAY_TIMER)
    else $error("power-up delay after a non power-on reset");
  a_wdt_off: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (ce_i && !cfg_r.watchdog_en) |=> !wdt_to)
    else $error("disabled watchdog timed out");
  a_cfg_addr_only: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (ce_i && prog_i.rd && prog_i.addr != CWR_CFG_ADDR) |=> prog_rdata_o == 14'h0)
    else $error("config word answered at another address");
  a_ext_wakes: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (ce_i && ext_rst) |=> !sleep_r)
    else $error("external reset did not end sleep");
endmodule : cwr_top
`default_nettype wire

// >>> pkg/cwr_pkg.sv
// Package of constants and carrier types for the configuration word and reset timers block.
`default_nettype none
package cwr_pkg;
  // Configuration space and word location.
  localparam logic [13:0] CWR_CFG_ADDR = 14'h2007;
  localparam logic [13:0] CWR_CFG_SPACE_LO = 14'h2000;
  localparam logic [13:0] CWR_CFG_SPACE_HI = 14'h3FFF;
  localparam int CWR_CFG_W = 14;
  // Field positions inside the configuration word.
  localparam int CWR_B_PROTECT = 13;
  localparam int CWR_B_DATA_PROT = 8;
  localparam int CWR_B_LVP = 7;
  localparam int CWR_B_BOR_EN = 6;
  localparam int CWR_B_EXT_RST = 5;
  localparam int CWR_B_FOSC2 = 4;
  localparam int CWR_B_POWERUP_DELAY_TIMER_EN = 3;
  localparam int CWR_B_WDT_EN = 2;
  localparam int CWR_B_FOSC1 = 1;
  localparam int CWR_B_FOSC0 = 0;
  // Erased word: every implemented bit unprogrammed, bits 12-9 read as zero.
  localparam logic [13:0] CWR_CFG_ERASED = 14'h21FF;
  localparam logic [13:0] CWR_CFG_IMPL_MASK = 14'h21FF;
  // Protected upper address for each variant.
  localparam logic [13:0] CWR_PROT_TOP_L = 14'h0FFF;
  localparam logic [13:0] CWR_PROT_TOP_M = 14'h07FF;
  localparam logic [13:0] CWR_PROT_TOP_S = 14'h03FF;
  // Oscillator select codes.
  localparam logic [2:0] CWR_OSC_RC_CLK = 3'h7;
  localparam logic [2:0] CWR_OSC_RC_IO = 3'h6;
  localparam logic [2:0] CWR_OSC_INT_CLK = 3'h5;
  localparam logic [2:0] CWR_OSC_INT_IO = 3'h4;
  localparam logic [2:0] CWR_OSC_EXT = 3'h3;
  localparam logic [2:0] CWR_OSC_HS = 3'h2;
  localparam logic [2:0] CWR_OSC_XT = 3'h1;
  localparam logic [2:0] CWR_OSC_LP = 3'h0;
  // Timing.
  localparam int CWR_CLK_HZ = 25000000;
  localparam int CWR_POWERUP_DELAY_TIMER_MS = 72;
  localparam int CWR_POWERUP_DELAY_TIMER_CYC = (CWR_CLK_HZ / 1000) * CWR_POWERUP_DELAY_TIMER_MS;
  localparam int CWR_OST_CYC = 1024;
  localparam int CWR_WDT_CYC = 18;
  // Decoded settings carrier.
  typedef enum logic [2:0] {
    CWR_SRC_RC = 3'h1,
    CWR_SRC_INT = 3'h2,
    CWR_SRC_EXT = 3'h3,
    CWR_SRC_HS = 3'h4,
    CWR_SRC_XT = 3'h5,
    CWR_SRC_LP = 3'h6
  } cwr_src_t;
  typedef struct packed {
    logic program_protect_bit;
    logic data_array_protect_bit;
    logic low_voltage_programming_en;
    logic brownout_reset_en;
    logic external_reset_pin_en;
    logic powerup_delay_en;
    logic watchdog_en;
    logic [2:0] osc_source_select;
    cwr_src_t source;
    logic clkout_en;
    logic crystal;
  } cwr_cfg_t;
  // Programmer port bundle.
  typedef struct packed {
    logic [13:0] addr;
    logic [13:0] wdata;
    logic wr;
    logic rd;
  } cwr_prog_req_t;
endpackage : cwr_pkg
`default_nettype wire

// >>> rtl/cwr_sync.sv
// Two-flop synchroniser for inputs from outside the clock domain.
`timescale 1ns/100ps
`default_nettype none
module cwr_sync #(
  parameter int W = 1
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_r;
  // The first stage feeds only the second stage; both freeze with the clock enable.
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta_r <= '0;
      q_o <= '0;
    end else if (ce_i) begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule : cwr_sync
`default_nettype wire

// >>> rtl/cwr_watchdog.sv
// Watchdog counter clocked by enables from its own RC oscillator.
`timescale 1ns/100ps
`default_nettype none
module cwr_watchdog #(
  parameter int LIMIT = 18
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic enable_i,
  input wire logic rc_tick_i,
  input wire logic clear_i,
  output logic timeout_o
);
  logic [31:0] count_r;
  // Counts only watchdog RC ticks, so the core clock rate never shifts the period.
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      count_r <= 32'h0;
      timeout_o <= 1'b0;
    end else if (ce_i) begin
      timeout_o <= 1'b0;
      if (!enable_i || clear_i) begin
        count_r <= 32'h0;
      end else if (rc_tick_i) begin
        if (count_r == 32'(LIMIT - 1)) begin
          count_r <= 32'h0;
          timeout_o <= 1'b1;
        end else begin
          count_r <= count_r + 32'h1;
        end
      end
    end
  end
endmodule : cwr_watchdog
`default_nettype wire

// >>> verification/cwr_prog_model.sv
// Programmer model that reaches the configuration space over the same-clock port.
`timescale 1ns/100ps
`default_nettype none
module cwr_prog_model (
  input wire logic sys_clk_i,
  input wire logic [13:0] prog_rdata_i,
  output logic prog_mode_o,
  output cwr_pkg::cwr_prog_req_t prog_o
);
  import cwr_pkg::*;
  initial begin
    prog_mode_o = 1'b0;
    prog_o = '0;
  end
  // Mode changes get four cycles to pass the input synchroniser before any access.
  task automatic set_mode(input logic m);
    @(posedge sys_clk_i);
    prog_mode_o <= m;
    repeat (4) @(posedge sys_clk_i);
  endtask : set_mode
  // One-cycle write; afterwards the bus carries inverted values so stale data prove nothing.
  task automatic wr_word(input logic [13:0] a, input logic [13:0] d);
    @(posedge sys_clk_i);
    prog_o <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk_i);
    prog_o <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
  endtask : wr_word
  // Read data stand only in the cycle after the strobe, so they are taken there.
  task automatic rd_word(input logic [13:0] a, output logic [13:0] d);
    @(posedge sys_clk_i);
    prog_o <= '{addr: a, wdata: 14'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk_i);
    prog_o <= '{addr: ~a, wdata: 14'h3FFF, wr: 1'b0, rd: 1'b0};
    #1;
    d = prog_rdata_i;
  endtask : rd_word
endmodule : cwr_prog_model
`default_nettype wire

// >>> verification/tb.sv
// Self-checking bench for the configuration word and reset sequencing block.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import cwr_pkg::*;
  localparam int POWERUP_DELAY_TIMER = 20;
  logic sys_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic power_on_i = 1'b0;
  logic ext_reset_n_i = 1'b1;
  logic brownout_i = 1'b0;
  logic wdt_rc_i = 1'b0;
  logic osc_stable_i = 1'b1;
  logic rc_run = 1'b0;
  logic cpu_sleep_i = 1'b0;
  logic irq_pending_i = 1'b0;
  logic data_rd = 1'b0;
  logic data_wr = 1'b0;
  logic ce = 1'b1;
  logic wdt_clear = 1'b0;
  logic [13:0] fetch_addr = 14'h0000;
  logic prog_mode;
  cwr_prog_req_t prog;
  logic [13:0] prog_rdata;
  logic device_reset, asleep, wake, blocked, rd_grant, wr_grant, wdt_to;
  logic [3:0] mon;
  cwr_cfg_t cfg;
  int mismatches = 0;
  int checks = 0;
  logic [13:0] rd;
  int n;
  assign mon = {wdt_to, wake, asleep, device_reset};
  always #20 sys_clk_i = ~sys_clk_i;
  // The watchdog oscillator runs only when asked, one tick every two cycles.
  always @(posedge sys_clk_i) begin
    if (rc_run) wdt_rc_i <= ~wdt_rc_i;
  end
  // Short counts keep the run brief; expectations derive from POWERUP_DELAY_TIMER.
  cwr_top #(.POWERUP_DELAY_TIMER_CYC(POWERUP_DELAY_TIMER), .OST_CYC(4), .WDT_CYC(4)) cwr_top_inst (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .ce_i(ce), .power_on_i(power_on_i),
    .ext_reset_n_i(ext_reset_n_i), .brownout_i(brownout_i), .wdt_rc_i(wdt_rc_i),
    .osc_stable_i(osc_stable_i), .prog_mode_i(prog_mode), .prog_i(prog),
    .cpu_fetch_addr_i(fetch_addr), .cpu_sleep_i(cpu_sleep_i), .cpu_wdt_clear_i(wdt_clear),
    .irq_pending_i(irq_pending_i), .cpu_data_rd_i(data_rd), .cpu_data_wr_i(data_wr),
    .prog_rdata_o(prog_rdata), .device_reset_o(device_reset), .asleep_o(asleep),
    .wake_o(wake), .fetch_blocked_o(blocked), .data_rd_grant_o(rd_grant),
    .data_wr_grant_o(wr_grant), .wdt_timeout_o(wdt_to), .cfg_o(cfg));
  cwr_prog_model cwr_prog_model_inst (
    .sys_clk_i(sys_clk_i), .prog_rdata_i(prog_rdata), .prog_mode_o(prog_mode), .prog_o(prog));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic stop_test;
    if (mismatches == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test
  // Bounded wait for one monitored output to reach a level; n returns the cycles taken.
  task automatic wait_lvl(input int i, input logic lvl, input int bound);
    n = 0;
    while (mon[i] !== lvl) begin
      @(posedge sys_clk_i);
      #1;
      n++;
      if (n > bound) begin
        chk(32'h0, 32'h1);
        stop_test();
      end
    end
  endtask : wait_lvl
  // Program a word, then pulse the external reset so the new settings are latched.
  task automatic load(input logic [13:0] w);
    cwr_prog_model_inst.set_mode(1'b1);
    cwr_prog_model_inst.wr_word(CWR_CFG_ADDR, w);
    cwr_prog_model_inst.set_mode(1'b0);
    ext_reset_n_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    ext_reset_n_i <= 1'b1;
  endtask : load
  function automatic cwr_src_t exp_src(input logic [2:0] c);
    case (c)
      3'h7, 3'h6: return CWR_SRC_RC;
      3'h5, 3'h4: return CWR_SRC_INT;
      3'h3: return CWR_SRC_EXT;
      3'h2: return CWR_SRC_HS;
      3'h1: return CWR_SRC_XT;
      default: return CWR_SRC_LP;
    endcase
  endfunction : exp_src
  // Main sequence: power-up, programmer access, decode, timers, brown-out, protection, sleep.
  initial begin
    repeat (6) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    @(posedge sys_clk_i);
    power_on_i <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    wait_lvl(0, 1'b0, 100);
    cwr_prog_model_inst.set_mode(1'b1);
    cwr_prog_model_inst.rd_word(CWR_CFG_ADDR, rd);
    chk(rd, CWR_CFG_ERASED);
    cwr_prog_model_inst.rd_word(14'h2006, rd);
    chk(rd, 14'h0000);
    cwr_prog_model_inst.wr_word(CWR_CFG_ADDR, 14'h3FFF);
    cwr_prog_model_inst.rd_word(CWR_CFG_ADDR, rd);
    chk(rd, 14'h21FF);
    // A write while the clock enable is low must be lost.
    ce <= 1'b0;
    cwr_prog_model_inst.wr_word(CWR_CFG_ADDR, 14'h1E00);
    ce <= 1'b1;
    cwr_prog_model_inst.rd_word(CWR_CFG_ADDR, rd);
    chk(rd, 14'h21FF);
    cwr_prog_model_inst.wr_word(CWR_CFG_ADDR, 14'h1E00);
    cwr_prog_model_inst.rd_word(CWR_CFG_ADDR, rd);
    chk(rd, 14'h0000);
    cwr_prog_model_inst.set_mode(1'b0);
    cwr_prog_model_inst.wr_word(CWR_CFG_ADDR, 14'h21FF);
    cwr_prog_model_inst.rd_word(CWR_CFG_ADDR, rd);
    chk(rd, 14'h0000);
    // Back in programming mode the refused write must have left the word alone.
    cwr_prog_model_inst.set_mode(1'b1);
    cwr_prog_model_inst.rd_word(CWR_CFG_ADDR, rd);
    chk(rd, 14'h0000);
    for (int c = 0; c < 8; c++) begin
      load(14'h21EC | {9'h000, c[2], 2'h0, c[1:0]});
      wait_lvl(0, 1'b0, 100);
      chk(cfg.osc_source_select, c[2:0]);
      chk(cfg.source, exp_src(c[2:0]));
    end
    load(14'h21F7);
    wait_lvl(0, 1'b0, 100);
    chk(n < POWERUP_DELAY_TIMER, 1'b1);
    power_on_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    power_on_i <= 1'b1;
    wait_lvl(0, 1'b1, 10);
    wait_lvl(0, 1'b0, 200);
    chk(n >= POWERUP_DELAY_TIMER, 1'b1);
    osc_stable_i <= 1'b0;
    load(14'h21EE);
    repeat (30) @(posedge sys_clk_i);
    chk(device_reset, 1'b1);
    osc_stable_i <= 1'b1;
    wait_lvl(0, 1'b0, 20);
    load(14'h21BF);
    wait_lvl(0, 1'b0, 100);
    chk(cfg.brownout_reset_en, 1'b0);
    brownout_i <= 1'b1;
    repeat (8) @(posedge sys_clk_i);
    chk(device_reset, 1'b0);
    brownout_i <= 1'b0;
    load(14'h01FF);
    wait_lvl(0, 1'b0, 100);
    chk(cfg.brownout_reset_en, 1'b1);
    @(posedge sys_clk_i);
    brownout_i <= 1'b1;
    wait_lvl(0, 1'b1, 8);
    chk(device_reset, 1'b1);
    brownout_i <= 1'b0;
    wait_lvl(0, 1'b0, 100);
    fetch_addr <= CWR_PROT_TOP_L;
    cwr_prog_model_inst.set_mode(1'b1);
    #1;
    chk(blocked, 1'b1);
    fetch_addr <= 14'h1000;
    cwr_prog_model_inst.wr_word(CWR_CFG_ADDR, 14'h21FF);
    repeat (2) @(posedge sys_clk_i);
    #1;
    chk(blocked, 1'b0);
    cwr_prog_model_inst.set_mode(1'b0);
    chk(cfg.program_protect_bit, 1'b0);
    data_rd <= 1'b1;
    @(posedge sys_clk_i);
    data_rd <= 1'b0;
    data_wr <= 1'b1;
    #1;
    chk({rd_grant, wr_grant}, 2'h2);
    @(posedge sys_clk_i);
    data_wr <= 1'b0;
    #1;
    chk({rd_grant, wr_grant}, 2'h1);
    @(posedge sys_clk_i);
    cpu_sleep_i <= 1'b1;
    wait_lvl(1, 1'b1, 6);
    @(posedge sys_clk_i);
    irq_pending_i <= 1'b1;
    cpu_sleep_i <= 1'b0;
    wait_lvl(2, 1'b1, 8);
    chk(wake, 1'b1);
    @(posedge sys_clk_i);
    #1;
    chk({wake, asleep}, 2'h0);
    @(posedge sys_clk_i);
    irq_pending_i <= 1'b0;
    cpu_sleep_i <= 1'b1;
    wait_lvl(1, 1'b1, 6);
    @(posedge sys_clk_i);
    rc_run <= 1'b1;
    cpu_sleep_i <= 1'b0;
    wait_lvl(2, 1'b1, 100);
    chk(wake, 1'b1);
    // A clear held high keeps an awake device out of reset.
    @(posedge sys_clk_i);
    wdt_clear <= 1'b1;
    n = 0;
    repeat (40) begin
      @(posedge sys_clk_i);
      #1;
      n += device_reset;
    end
    chk(n, 0);
    wdt_clear <= 1'b0;
    wait_lvl(3, 1'b1, 40);
    chk(device_reset, 1'b1);
    wait_lvl(0, 1'b0, 40);
    // With the enable bit programmed the watchdog must stay silent.
    load(14'h21FB);
    wait_lvl(0, 1'b0, 100);
    n = 0;
    repeat (40) begin
      @(posedge sys_clk_i);
      #1;
      n += device_reset;
    end
    chk(n, 0);
    rc_run <= 1'b0;
    stop_test();
  end
endmodule : tb
`default_nettype wire
